// ===== src/pief_flag.sv
`timescale 1ns/100ps

// Sticky flag: event set wins over software clear
module pief_flag
	import pief_pkg::*;
(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic set,
	input  wire logic clr,
	output logic      q
);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= 1'b0;
		end else if (set) begin
			q <= 1'b1;
		end else if (clr) begin
			q <= 1'b0;
		end
	end

endmodule

// ===== src/pief_pkg.sv
package pief_pkg;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] PIEF_ADDR_EN2     = 4'h0;
	localparam logic [3:0] PIEF_ADDR_REQ1    = 4'h1;
	localparam logic [3:0] PIEF_ADDR_MASTER  = 4'h2;
	localparam logic [3:0] PIEF_ADDR_STATUS  = 4'h3;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int PIEF_EN_OSC_FAIL   = 7;
	localparam int PIEF_EN_CMP_B      = 6;
	localparam int PIEF_EN_CMP_A      = 5;
	localparam int PIEF_EN_NVM        = 4;
	localparam int PIEF_EN_BUS_COLL   = 3;
	localparam int PIEF_EN_LOW_POWER  = 2;
	localparam int PIEF_EN_CAPCOMP_B  = 0;

	localparam int PIEF_RQ_CONV_DONE  = 6;
	localparam int PIEF_RQ_RX_FULL    = 5;
	localparam int PIEF_RQ_TX_EMPTY   = 4;
	localparam int PIEF_RQ_SYNC_SER   = 3;
	localparam int PIEF_RQ_CAPCOMP_A  = 2;
	localparam int PIEF_RQ_TIMER_B    = 1;
	localparam int PIEF_RQ_TIMER_A    = 0;

	localparam int PIEF_MS_GLOBAL     = 7;
	localparam int PIEF_MS_PERIPH     = 6;

	// ----------------------------------------
	// Masks and reset values
	// ----------------------------------------
	localparam logic [7:0] PIEF_EN2_MASK     = 8'hFD;
	localparam logic [7:0] PIEF_REQ1_MASK    = 8'h7F;
	localparam logic [7:0] PIEF_REQ1_SW_MASK = 8'h4F;
	localparam logic [7:0] PIEF_MASTER_MASK  = 8'hC0;
	localparam logic [7:0] PIEF_EN2_RST      = 8'h00;
	localparam logic [7:0] PIEF_REQ1_RST     = 8'h00;
	localparam logic [7:0] PIEF_MASTER_RST   = 8'h00;

	// Width of request-one; seven event flags, bit 7 reads zero
	localparam int PIEF_NUM_EVT = 8;

endpackage

// ===== src/pief_top.sv
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps

module pief_top
	import pief_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	// Avalon-MM slave, word addresses
	input  wire logic [3:0] avs_address,
	input  wire logic       avs_read,
	input  wire logic       avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0] avs_byteenable,
	output logic [31:0]     avs_readdata,
	output logic            avs_waitrequest,
	// Event pulses from peripherals, same clock
	input  wire logic       evt_conversion_done,
	input  wire logic       evt_sync_serial,
	input  wire logic       evt_capcomp_a,
	input  wire logic       evt_timer_b_match,
	input  wire logic       evt_timer_a_overflow,
	// Serial buffer state from the async serial port
	input  wire logic       serial_rx_full_set,
	input  wire logic       serial_rx_data_reg_read,
	input  wire logic       serial_tx_empty_set,
	input  wire logic       serial_tx_data_reg_write,
	// Second request register flags, owned elsewhere
	input  wire logic [7:0] periph_irq_request_two,
	// Requests out
	output logic            periph_irq_req,
	output logic            cpu_irq_req
);

	// ----------------------------------------
	// Bus handshake: one wait cycle per access
	// ----------------------------------------
	logic        ack_r;
	logic        acc;
	logic        wr_hit;
	logic [7:0]  wdata;

	assign acc    = (avs_read | avs_write) & ~ack_r;
	assign wdata  = avs_writedata[7:0];
	// Writes land at the edge that sees waitrequest low
	assign wr_hit = avs_write & ack_r & avs_byteenable[0];

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= acc;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= ~acc;
		end
	end

	function automatic logic wr_to(input logic [3:0] a);
		wr_to = wr_hit && (avs_address == a);
	endfunction

	// Pending term shared by both request outputs
	function automatic logic pending(
		input logic [7:0] rq2,
		input logic [7:0] en2,
		input logic [7:0] rq1
	);
		pending = (|(rq2 & en2)) | (|rq1);
	endfunction

	// ----------------------------------------
	// Enable-two and master registers
	// ----------------------------------------
	logic [7:0] periph_irq_enable_two_r;
	logic [7:0] master_r;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			periph_irq_enable_two_r <= PIEF_EN2_RST;
		end else if (wr_to(PIEF_ADDR_EN2)) begin
			periph_irq_enable_two_r <= wdata & PIEF_EN2_MASK;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			master_r <= PIEF_MASTER_RST;
		end else if (wr_to(PIEF_ADDR_MASTER)) begin
			master_r <= wdata & PIEF_MASTER_MASK;
		end
	end

	// ----------------------------------------
	// Request-one flags
	// ----------------------------------------
	logic [7:0] req1;
	logic [7:0] set_vec;
	logic [7:0] clr_vec;
	logic       wr_req1;

	assign wr_req1 = wr_to(PIEF_ADDR_REQ1);

	always_comb begin
		set_vec = 8'h00;
		clr_vec = 8'h00;
		// events set flags with no enable qualification
		set_vec[PIEF_RQ_CONV_DONE] = evt_conversion_done;
		set_vec[PIEF_RQ_RX_FULL]   = serial_rx_full_set;
		set_vec[PIEF_RQ_TX_EMPTY]  = serial_tx_empty_set;
		set_vec[PIEF_RQ_SYNC_SER]  = evt_sync_serial;
		set_vec[PIEF_RQ_CAPCOMP_A] = evt_capcomp_a;
		set_vec[PIEF_RQ_TIMER_B]   = evt_timer_b_match;
		set_vec[PIEF_RQ_TIMER_A]   = evt_timer_a_overflow;
		// Software clears only writable flags written to zero
		clr_vec = {8{wr_req1}} & ~wdata & PIEF_REQ1_SW_MASK;
		clr_vec[PIEF_RQ_RX_FULL]  = serial_rx_data_reg_read;
		clr_vec[PIEF_RQ_TX_EMPTY] = serial_tx_data_reg_write;
	end

	genvar g;
	generate
		for (g = 0; g < PIEF_NUM_EVT - 1; g++) begin : g_flag
			pief_flag u_flag (
				.clk    (clk),
				.arst_n (arst_n),
				.set    (set_vec[g]),
				.clr    (clr_vec[g]),
				.q      (req1[g])
			);
		end
	endgenerate

	assign req1[7] = 1'b0;

	// ----------------------------------------
	// Interrupt requests
	// ----------------------------------------
	// Neighbouring enable-one is not held here; request-one flags use
	// the status of their own peripheral enable outside this block.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			periph_irq_req <= 1'b0;
		end else begin
			periph_irq_req <= pending(periph_irq_request_two,
				periph_irq_enable_two_r, req1);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cpu_irq_req <= 1'b0;
		end else begin
			cpu_irq_req <= master_r[PIEF_MS_GLOBAL]
				& master_r[PIEF_MS_PERIPH]
				& pending(periph_irq_request_two,
				periph_irq_enable_two_r, req1);
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read & ~ack_r) begin
			unique case (avs_address)
				PIEF_ADDR_EN2:    avs_readdata <= {24'h000000,
					periph_irq_enable_two_r};
				PIEF_ADDR_REQ1:   avs_readdata <= {24'h000000, req1};
				PIEF_ADDR_MASTER: avs_readdata <= {24'h000000, master_r};
				PIEF_ADDR_STATUS: avs_readdata <= {30'h0000000,
					cpu_irq_req, periph_irq_req};
				default:          avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

endmodule

// ===== tb/pief_asserts.sv
`timescale 1ns/100ps
module pief_asserts (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	input  wire logic        evt_conversion_done,
	input  wire logic        evt_sync_serial,
	input  wire logic        evt_capcomp_a,
	input  wire logic        evt_timer_b_match,
	input  wire logic        evt_timer_a_overflow,
	input  wire logic        serial_rx_full_set,
	input  wire logic        periph_irq_req,
	input  wire logic        cpu_irq_req
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	property p_sets(ev);
		ev |-> ##2 periph_irq_req;
	endproperty
	a_conv_irq: assert property (p_sets(evt_conversion_done))
		else $error("conversion event gave no request");
	a_sync_irq: assert property (p_sets(evt_sync_serial))
		else $error("sync serial event gave no request");
	a_capcomp_irq: assert property (p_sets(evt_capcomp_a))
		else $error("capcomp event gave no request");
	a_timer_b_irq: assert property (p_sets(evt_timer_b_match))
		else $error("timer b event gave no request");
	a_timer_a_irq: assert property (p_sets(evt_timer_a_overflow))
		else $error("timer a event gave no request");
	a_rx_full_irq: assert property (p_sets(serial_rx_full_set))
		else $error("rx full gave no request");
	a_cpu_gated: assert property (cpu_irq_req |-> periph_irq_req)
		else $error("cpu request without peripheral request");
	a_upper_zero: assert property (!avs_waitrequest |->
		avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
	a_answer_one: assert property ($rose(avs_read | avs_write) |=>
		!avs_waitrequest ##1 avs_waitrequest) else $error("bus answer late");
	c_cpu: cover property (cpu_irq_req);
	c_write: cover property (avs_write && !avs_waitrequest);
	c_conv: cover property (evt_conversion_done);
endmodule

bind pief_top pief_asserts pief_asserts_i (.*);

// ===== tb/pief_periph_model.sv
`timescale 1ns/100ps
module pief_periph_model (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic [8:0] fire,
	output logic      [8:0] evt
);
	// Command is registered and appears as the event one cycle later
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			evt <= 9'h000;
		end else begin
			evt <= fire;
		end
	end
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
	miscompares++; $display("Error %s exp %h got %h", n, e, s); end end
module tb;
	import pief_pkg::*;
	logic        clk = 0, arst_n = 0, rd = 0, wr = 0, wt, pirq, cirq;
	logic [3:0]  adr = 0;
	logic [31:0] wd = 0, q, rdat;
	logic [8:0]  fire = 0, ev;
	logic [7:0]  rq2 = 0;
	logic [3:0]  be = 4'hF;
	int          miscompares = 0, n_compared = 0, en, rq = 0, i, x;
	int          evq[$] = '{6, 3, 2, 1, 0, 5, 4};
	always #5 clk = ~clk;
	pief_periph_model pief_periph_model_i (.clk(clk), .arst_n(arst_n),
		.fire(fire), .evt(ev));
	pief_top pief_top_i (.clk(clk), .arst_n(arst_n), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt),
		.evt_conversion_done(ev[6]), .evt_sync_serial(ev[3]),
		.evt_capcomp_a(ev[2]), .evt_timer_b_match(ev[1]),
		.evt_timer_a_overflow(ev[0]), .serial_rx_full_set(ev[5]),
		.serial_tx_empty_set(ev[4]), .serial_rx_data_reg_read(ev[7]),
		.serial_tx_data_reg_write(ev[8]), .periph_irq_request_two(rq2),
		.periph_irq_req(pirq), .cpu_irq_req(cirq));
	task summarize;
		if (miscompares == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task acc(input logic w, input logic [3:0] a, input int d);
		int n;
		n = 0;
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		do begin
			@(posedge clk);
			n++;
		end while (wt !== 1'b0 && n < 20);
		if (wt !== 1'b0) begin
			miscompares++;
			summarize;
		end
		q = rdat;
		rd <= 0;
		wr <= 0;
		@(posedge clk);
	endtask
	task fire_ev(input int b);
		fire <= 9'(1 << b);
		@(posedge clk);
		fire <= 0;
		@(posedge clk);
	endtask
	initial begin
		x = $urandom(32'hF855);
		repeat (12) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		acc(0, PIEF_ADDR_EN2, 0);
		`CHK("en2 reset", 0, q)
		acc(0, PIEF_ADDR_REQ1, 0);
		`CHK("req1 reset", 0, q)
		for (i = 0; i < 4; i++) begin
			x = $urandom & 8'hFF;
			acc(1, PIEF_ADDR_EN2, x);
			acc(0, PIEF_ADDR_EN2, 0);
			`CHK("en2", x & 8'hFD, q)
		end
		be <= 4'h2;
		acc(1, PIEF_ADDR_EN2, 8'hFF);
		be <= 4'hF;
		acc(0, PIEF_ADDR_EN2, 0);
		`CHK("en2 byteenable", x & 8'hFD, q)
		acc(1, PIEF_ADDR_EN2, 0);
		acc(1, PIEF_ADDR_REQ1, 8'hFF);
		acc(0, PIEF_ADDR_REQ1, 0);
		`CHK("req1 ones", 0, q)
		foreach (evq[k]) begin
			fire_ev(evq[k]);
			rq |= 1 << evq[k];
		end
		repeat (3) @(posedge clk);
		`CHK("pirq", 1'b1, pirq)
		`CHK("cirq off", 1'b0, cirq)
		acc(0, PIEF_ADDR_REQ1, 0);
		`CHK("req1 set", rq, q)
		acc(1, PIEF_ADDR_MASTER, 8'hC0);
		repeat (2) @(posedge clk);
		acc(0, PIEF_ADDR_STATUS, 0);
		`CHK("status", 3, q)
		acc(1, PIEF_ADDR_REQ1, 0);
		rq &= 8'h30;
		acc(0, PIEF_ADDR_REQ1, 0);
		`CHK("req1 clear", rq, q)
		fire_ev(7);
		fire_ev(8);
		acc(0, PIEF_ADDR_REQ1, 0);
		`CHK("req1 serial", 0, q)
		acc(0, 4'h9, 0);
		`CHK("unmapped", 0, q)
		for (i = 0; i < 6; i++) begin
			x = $urandom;
			rq2 <= 8'(x);
			en = (x >> 8) & 8'hFD;
			acc(1, PIEF_ADDR_EN2, x >> 8);
			repeat (2) @(posedge clk);
			`CHK("pirq two", 1'((x & en & 8'hFF) != 0), pirq)
			`CHK("cirq two", 1'((x & en & 8'hFF) != 0), cirq)
		end
		summarize;
	end
endmodule
